// ===== hw/pcp_device.sv
`timescale 1ns/1ps
`default_nettype none
module pcp_device #(
    parameter int BUF_WORDS = pcp_pkg::BUF_WORDS
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    pcp_if.dev        bus,
    input  wire logic refresh_req_i,
    output logic      cfg_valid_o,
    output logic      generic2_mode_o,
    output logic      gpio_as_output_o,
    output logic      big_endian_o,
    output logic      int_clk_tick_o
);
    import pcp_pkg::*;

    // ************************************************
    // Strap capture
    // ************************************************
    logic               cfg_done_q;
    logic [STRAP_W-1:0] straps_q;

    // Caught on the first edge after release, never in the reset branch
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cfg_done_q <= 1'b0;
            straps_q   <= STRAP_RST;
        end
        else if (!cfg_done_q)
        begin
            cfg_done_q <= 1'b1;
            straps_q   <= bus.straps;
        end
    end

    wire       gen2_w    = cfg_done_q &&
                           (straps_q[BUS_MODE_LSB +: 3] == BUS_MODE_GENERIC2);
    wire       big_end_w = straps_q[BYTE_ORDER_BIT];
    wire       wait_pol_w = straps_q[WAIT_POL_BIT];
    wire [1:0] bdiv_w    = straps_q[BCLK_DIV_LSB +: 2];

    assign cfg_valid_o      = cfg_done_q;
    assign generic2_mode_o  = gen2_w;
    assign gpio_as_output_o = cfg_done_q && !straps_q[GPIO_DIR_BIT];
    assign big_endian_o     = big_end_w;

    // ************************************************
    // Strobe synchronisers
    // ************************************************
    logic [3:0] sa_q;
    logic [3:0] sb_q;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sa_q <= 4'hF;
            sb_q <= 4'hF;
        end
        else
        begin
            sa_q <= {bus.chip_sel_n, bus.read_strobe_n,
                     bus.low_write_strobe_n, bus.high_byte_enable_n};
            sb_q <= sa_q;
        end
    end

    // Bus start and direction are ignored in this mode
    wire cs_w    = !sb_q[3];
    wire rd_w    = !sb_q[2];
    wire we_lo_w = !sb_q[1];
    wire we_hi_w = !sb_q[0];
    wire active_w = gen2_w && cs_w && (rd_w || we_lo_w || we_hi_w);
    wire write_w  = !rd_w && (we_lo_w || we_hi_w);

    // ************************************************
    // Bus clock and internal clock dividers
    // ************************************************
    logic [1:0] bdiv_cnt_q;
    logic [3:0] clkdiv_q;
    logic [3:0] int_cnt_q;
    logic       int_tick_q;

    // Host clock is free running, so the divider needs no frame
    wire bus_tick_w = (bdiv_cnt_q == bdiv_w);

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bdiv_cnt_q <= 2'h0;
            int_cnt_q  <= 4'h0;
            int_tick_q <= 1'b0;
        end
        else
        begin
            bdiv_cnt_q <= bus_tick_w ? 2'h0 : bdiv_cnt_q + 2'h1;
            int_cnt_q  <= (int_cnt_q >= clkdiv_q) ? 4'h0 : int_cnt_q + 4'h1;
            int_tick_q <= (int_cnt_q >= clkdiv_q);
        end
    end

    assign int_clk_tick_o = int_tick_q;

    // ************************************************
    // Address decode and data lanes
    // ************************************************
    wire [ADDR_W-1:0]  addr_w  = bus.host_address_in;
    wire               mem_w   = bus.mem_reg_sel;
    wire [ADDR_W-2:0]  widx_w  = addr_w[ADDR_W-1:1];
    wire               in_buf_w = (32'(widx_w) < BUF_WORDS);
    wire [DATA_W-1:0]  raw_wd_w = bus.host_data_io;
    wire [DATA_W-1:0]  wd_w    = big_end_w ? {raw_wd_w[7:0], raw_wd_w[15:8]}
                                            : raw_wd_w;
    wire               lane_hi_w = big_end_w ? we_lo_w : we_hi_w;
    wire               lane_lo_w = big_end_w ? we_hi_w : we_lo_w;

    logic [DATA_W-1:0] mem_q [0:BUF_WORDS-1];
    logic [DATA_W-1:0] reg_rd_w;
    logic [DATA_W-1:0] rd_mux_w;

    // Unmapped register offsets read as zero
    assign reg_rd_w =
        (addr_w == REG_STRAPS_OFS) ? {8'h00, straps_q} :
        (addr_w == REG_CLKDIV_OFS) ? {12'h000, clkdiv_q} :
        (addr_w == REG_STATUS_OFS) ? {13'h0000, refresh_req_i, gen2_w, cfg_done_q} :
        16'h0000;
    // Buffer above 80K bytes in the upper block reads as zero
    assign rd_mux_w = mem_w ? (in_buf_w ? mem_q[widx_w] : 16'h0000)
                            : reg_rd_w;

    // ************************************************
    // Access state machine
    // ************************************************
    pcp_dev_st_e       st_q;
    logic [DATA_W-1:0] rdata_q;
    wire               grant_w = (st_q == DST_ARB) && bus_tick_w && !refresh_req_i;
    wire               do_wr_w = grant_w && write_w;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q    <= DST_IDLE;
            rdata_q <= 16'h0000;
        end
        else
        begin
            case (st_q)
                DST_IDLE:
                begin
                    if (active_w)
                        st_q <= DST_ARB;
                end
                DST_ARB:
                begin
                    if (!active_w)
                        st_q <= DST_IDLE;
                    else if (grant_w)
                    begin
                        st_q    <= DST_DONE;
                        rdata_q <= rd_mux_w;
                    end
                end
                DST_DONE:
                begin
                    if (!active_w)
                        st_q <= DST_IDLE;
                end
                default:
                    st_q <= DST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            clkdiv_q <= CLKDIV_RST;
        else if (do_wr_w && !mem_w && addr_w == REG_CLKDIV_OFS && lane_lo_w)
            clkdiv_q <= wd_w[3:0];
    end

    // Buffer carries no reset; contents are undefined at power up
    always_ff @(posedge clk_i)
    begin
        if (do_wr_w && mem_w && in_buf_w && lane_hi_w)
            mem_q[widx_w][15:8] <= wd_w[15:8];
        if (do_wr_w && mem_w && in_buf_w && lane_lo_w)
            mem_q[widx_w][7:0] <= wd_w[7:0];
    end

    // ************************************************
    // Pin outputs
    // ************************************************
    wire wait_act_w = active_w && (st_q != DST_DONE);

    assign bus.wait_line     = wait_pol_w ? wait_act_w : !wait_act_w;
    assign bus.data_oe_dev   = (st_q == DST_DONE) && rd_w && cs_w;
    assign bus.data_from_dev = big_end_w ? {rdata_q[7:0], rdata_q[15:8]}
                                         : rdata_q;
endmodule
`default_nettype wire

// ===== hw/pcp_host.sv
`timescale 1ns/1ps
`default_nettype none
module pcp_host #(
    parameter bit         FULL_DECODE = 1'b0,
    parameter logic [7:0] BASE_PAGE   = 8'h00,
    parameter logic [1:0] BUS_DIV     = 2'h0,
    parameter bit         GPIO_INPUTS = 1'b1,
    parameter bit         WAIT_HIGH   = 1'b0
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    pcp_if.host              bus,
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [31:0]      reg_rdata_o
);
    import pcp_pkg::*;

    // ************************************************
    // Command registers
    // ************************************************
    pcp_host_st_e            st_q;
    logic [HOST_ADDR_W-1:0]  addr_q;
    logic [DATA_W-1:0]       wdata_q;
    logic [DATA_W-1:0]       rdata_q;
    logic [1:0]              be_q;
    logic                    is_wr_q;
    logic                    pins_on_q;
    logic                    done_q;
    logic [2:0]              cnt_q;
    logic [31:0]             rdo_q;

    wire ctrl_wr_w = reg_wr_i && reg_addr_i == HREG_CTRL;
    wire launch_w  = ctrl_wr_w && st_q == HST_IDLE &&
                     (reg_wdata_i[CTRL_READ_BIT] || reg_wdata_i[CTRL_WRITE_BIT]);
    // Without full decode every 256K image answers
    wire hit_w     = !FULL_DECODE || addr_q[HOST_ADDR_W-1:18] == BASE_PAGE;
    wire wait_on_w = WAIT_HIGH ? bus.wait_line : !bus.wait_line;
    wire finish_w  = st_q == HST_WAIT && cnt_q == 3'h0 && (!wait_on_w || !hit_w);
    wire clr_done_w = reg_wr_i && reg_addr_i == HREG_STAT &&
                      reg_wdata_i[STAT_DONE_BIT];

    // ************************************************
    // Transfer sequencer
    // ************************************************
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q      <= HST_IDLE;
            is_wr_q   <= 1'b0;
            be_q      <= 2'h3;
            pins_on_q <= 1'b0;
            cnt_q     <= 3'h0;
            rdata_q   <= 16'h0000;
        end
        else
        begin
            case (st_q)
                HST_IDLE:
                begin
                    if (launch_w)
                    begin
                        st_q      <= HST_WAIT;
                        is_wr_q   <= reg_wdata_i[CTRL_WRITE_BIT];
                        be_q      <= reg_wdata_i[CTRL_BE_LSB +: 2];
                        pins_on_q <= 1'b1;
                        cnt_q     <= WAIT_SETUP_CYC;
                    end
                end
                HST_WAIT:
                begin
                    if (cnt_q != 3'h0)
                        cnt_q <= cnt_q - 3'h1;
                    else if (finish_w)
                    begin
                        st_q      <= HST_RECOV;
                        pins_on_q <= 1'b0;
                        cnt_q     <= RECOVER_CYC;
                        if (!is_wr_q)
                            rdata_q <= hit_w ? bus.host_data_io : 16'hFFFF;
                    end
                end
                HST_RECOV:
                begin
                    if (cnt_q == 3'h0)
                        st_q <= HST_IDLE;
                    else
                        cnt_q <= cnt_q - 3'h1;
                end
                default:
                    st_q <= HST_IDLE;
            endcase
        end
    end

    // ************************************************
    // Register port
    // ************************************************
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            addr_q  <= 26'h0000000;
            wdata_q <= 16'h0000;
            done_q  <= 1'b0;
            rdo_q   <= 32'h00000000;
        end
        else
        begin
            if (reg_wr_i && reg_addr_i == HREG_ADDR && st_q == HST_IDLE)
                addr_q <= reg_wdata_i[HOST_ADDR_W-1:0];
            if (reg_wr_i && reg_addr_i == HREG_DATA && st_q == HST_IDLE)
                wdata_q <= reg_wdata_i[DATA_W-1:0];
            // Completion wins over a clear in the same cycle
            if (finish_w)
                done_q <= 1'b1;
            else if (clr_done_w)
                done_q <= 1'b0;
            if (reg_rd_i && reg_addr_i == HREG_ADDR)
                rdo_q <= {6'h00, addr_q};
            else if (reg_rd_i && reg_addr_i == HREG_DATA)
                rdo_q <= {16'h0000, rdata_q};
            else if (reg_rd_i && reg_addr_i == HREG_STAT)
                rdo_q <= {30'h00000000, done_q, st_q != HST_IDLE};
            else
                rdo_q <= 32'h00000000;
        end
    end

    assign reg_rdata_o = rdo_q;

    // ************************************************
    // Pins
    // ************************************************
    wire drive_w = pins_on_q && hit_w;

    assign bus.host_address_in    = addr_q[ADDR_W-1:0];
    assign bus.mem_reg_sel        = addr_q[ADDR_W];
    assign bus.chip_sel_n         = !drive_w;
    assign bus.read_strobe_n      = !(drive_w && !is_wr_q);
    assign bus.low_write_strobe_n = !(drive_w && is_wr_q && be_q[0]);
    assign bus.high_byte_enable_n = !(drive_w && be_q[1]);
    assign bus.bus_start_n        = 1'b1;
    assign bus.read_write_n       = 1'b1;
    assign bus.data_from_host     = wdata_q;
    assign bus.data_oe_host       = drive_w && is_wr_q;
    // Byte order forced little endian for this socket
    assign bus.straps = {BUS_DIV, WAIT_HIGH, 1'b0, GPIO_INPUTS,
                         BUS_MODE_GENERIC2};
endmodule
`default_nettype wire

// ===== hw/pcp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pcp_if;
    import pcp_pkg::*;
    logic [ADDR_W-1:0]  host_address_in;
    logic               mem_reg_sel;
    logic               chip_sel_n;
    logic               high_byte_enable_n;
    logic               low_write_strobe_n;
    logic               read_strobe_n;
    logic               bus_start_n;
    logic               read_write_n;
    logic               wait_line;
    logic [STRAP_W-1:0] straps;
    logic [DATA_W-1:0]  data_from_host;
    logic               data_oe_host;
    logic [DATA_W-1:0]  data_from_dev;
    logic               data_oe_dev;
    wire  [DATA_W-1:0]  host_data_io;

    // ************************************************
    // Shared data bus, pulled up when idle
    // ************************************************
    assign host_data_io = data_oe_dev ? data_from_dev :
                          data_oe_host ? data_from_host : 16'hFFFF;

    modport dev (
        input  host_address_in, mem_reg_sel, chip_sel_n, high_byte_enable_n,
        input  low_write_strobe_n, read_strobe_n, bus_start_n, read_write_n,
        input  straps, host_data_io,
        output wait_line, data_from_dev, data_oe_dev
    );
    modport host (
        output host_address_in, mem_reg_sel, chip_sel_n, high_byte_enable_n,
        output low_write_strobe_n, read_strobe_n, bus_start_n, read_write_n,
        output straps, data_from_host, data_oe_host,
        input  wait_line, host_data_io
    );
endinterface
`default_nettype wire

// ===== hw/pcp_pkg.sv
package pcp_pkg;
    // ************************************************
    // Pin widths and strap fields
    // ************************************************
    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;
    localparam int STRAP_W = 8;
    localparam int HOST_ADDR_W = 26;
    localparam int BUS_MODE_LSB = 0;
    localparam int GPIO_DIR_BIT = 3;
    localparam int BYTE_ORDER_BIT = 4;
    localparam int WAIT_POL_BIT = 5;
    localparam int BCLK_DIV_LSB = 6;
    localparam logic [2:0] BUS_MODE_GENERIC2 = 3'h4;
    localparam logic [STRAP_W-1:0] STRAP_RST = 8'h00;

    // ************************************************
    // Address map
    // ************************************************
    localparam int BLOCK_BYTES = 131072;
    localparam int ALIAS_BYTES = 262144;
    localparam int BUF_BYTES = 81920;
    localparam int BUF_WORDS = BUF_BYTES / 2;
    localparam logic [ADDR_W-1:0] REG_STRAPS_OFS = 17'h00000;
    localparam logic [ADDR_W-1:0] REG_CLKDIV_OFS = 17'h00002;
    localparam logic [ADDR_W-1:0] REG_STATUS_OFS = 17'h00004;
    localparam logic [3:0] CLKDIV_RST = 4'h0;

    // ************************************************
    // Host controller registers and timing
    // ************************************************
    localparam logic [3:0] HREG_ADDR = 4'h0;
    localparam logic [3:0] HREG_DATA = 4'h4;
    localparam logic [3:0] HREG_CTRL = 4'h8;
    localparam logic [3:0] HREG_STAT = 4'hC;
    localparam int CTRL_READ_BIT = 0;
    localparam int CTRL_WRITE_BIT = 1;
    localparam int CTRL_BE_LSB = 2;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam logic [2:0] WAIT_SETUP_CYC = 3'h4;
    localparam logic [2:0] RECOVER_CYC = 3'h3;

    typedef enum logic [1:0] {
        DST_IDLE = 2'b00,
        DST_ARB  = 2'b01,
        DST_DONE = 2'b10
    } pcp_dev_st_e;

    typedef enum logic [1:0] {
        HST_IDLE  = 2'b00,
        HST_WAIT  = 2'b01,
        HST_RECOV = 2'b10
    } pcp_host_st_e;
endpackage

// ===== tb/pcp_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pcp_link_sva
    import pcp_pkg::*;
(
    input wire logic               clk_i,
    input wire logic               rst_n_i,
    input wire logic [ADDR_W-1:0]  host_address_in,
    input wire logic               mem_reg_sel,
    input wire logic               chip_sel_n,
    input wire logic               high_byte_enable_n,
    input wire logic               low_write_strobe_n,
    input wire logic               read_strobe_n,
    input wire logic               bus_start_n,
    input wire logic               read_write_n,
    input wire logic               wait_line,
    input wire logic [STRAP_W-1:0] straps,
    input wire logic               data_oe_host,
    input wire logic               data_oe_dev
);
    // ********
    // Wait level decoded from the polarity strap
    // ********
    wire logic wait_act;
    assign wait_act = (wait_line == straps[WAIT_POL_BIT]);

    default clocking dclk @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_launch;
        $fell(chip_sel_n);
    endsequence
    sequence s_stall;
        ##[1:4] wait_act;
    endsequence
    sequence s_waiting;
        wait_act ##1 wait_act;
    endsequence

    tie_high_a: assert property (bus_start_n && read_write_n)
        else $error("bus start or direction not held high");
    mode_strap_a: assert property (straps[2:0] == BUS_MODE_GENERIC2)
        else $error("bus mode straps wrong");
    little_end_a: assert property (!straps[BYTE_ORDER_BIT])
        else $error("byte order strap not little endian");
    straps_stable_a: assert property ($stable(straps))
        else $error("straps moved after reset");
    strobe_excl_a: assert property (read_strobe_n || low_write_strobe_n)
        else $error("read and write strobes together");
    strobe_in_cs_a: assert property (
        !(read_strobe_n && low_write_strobe_n && high_byte_enable_n) |-> !chip_sel_n)
        else $error("strobe outside chip select");
    no_contend_a: assert property (!(data_oe_dev && data_oe_host))
        else $error("both ends drive data");
    wait_setup_a: assert property (s_launch |-> s_stall)
        else $error("no wait after access start");
    wait_bound_a: assert property (wait_act |-> ##[1:60] !wait_act)
        else $error("wait held too long");
    addr_hold_a: assert property (
        s_waiting |-> $stable(host_address_in) && $stable(mem_reg_sel))
        else $error("address moved during wait");
    dev_oe_a: assert property (data_oe_dev |-> low_write_strobe_n &&
        (!read_strobe_n || !$past(read_strobe_n) || !$past(read_strobe_n, 2)
         || !$past(read_strobe_n, 3)))
        else $error("device drives data outside read");
endmodule
`default_nettype wire

// ===== tb/tb_pc_card_host_port_config.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pc_card_host_port_config;
    import pcp_pkg::*;
    localparam logic [1:0]  DIV_P = 2'h3;
    localparam logic [7:0]  EXP_STRAPS = {DIV_P, 1'b0, 1'b0, 1'b1, BUS_MODE_GENERIC2};
    localparam logic [25:0] BUF_A = 26'h0020010;
    localparam int          LIMIT = 20000;
    logic        clk;
    logic        rst_n;
    logic        refresh_req;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        cfg_valid;
    logic        gen2;
    logic        gpio_out;
    logic        big_end;
    logic        tick;
    logic [16:0] seen_addr;
    logic        seen_sel;
    logic [15:0] seen_wdata;
    logic [15:0] seen_rdata;
    logic [15:0] last_q;
    logic [31:0] rd_val;
    int          bad_count;
    int          compares;
    int          cycles;
    int          n;

    pcp_if bus ();
    pcp_host #(.FULL_DECODE(1'b0), .BASE_PAGE(8'h00), .BUS_DIV(DIV_P), .GPIO_INPUTS(1'b1),
        .WAIT_HIGH(1'b0)) i_pcp_host (.clk_i(clk), .rst_n_i(rst_n), .bus(bus.host),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata));
    pcp_device #(.BUF_WORDS(BUF_WORDS)) i_pcp_device (.clk_i(clk), .rst_n_i(rst_n),
        .bus(bus.dev), .refresh_req_i(refresh_req), .cfg_valid_o(cfg_valid),
        .generic2_mode_o(gen2), .gpio_as_output_o(gpio_out), .big_endian_o(big_end),
        .int_clk_tick_o(tick));
    pcp_link_sva i_pcp_link_sva (.clk_i(clk), .rst_n_i(rst_n),
        .host_address_in(bus.host_address_in), .mem_reg_sel(bus.mem_reg_sel),
        .chip_sel_n(bus.chip_sel_n), .high_byte_enable_n(bus.high_byte_enable_n),
        .low_write_strobe_n(bus.low_write_strobe_n), .read_strobe_n(bus.read_strobe_n),
        .bus_start_n(bus.bus_start_n), .read_write_n(bus.read_write_n),
        .wait_line(bus.wait_line), .straps(bus.straps), .data_oe_host(bus.data_oe_host),
        .data_oe_dev(bus.data_oe_dev));

    always #12.5 clk = ~clk;

    // ********
    // Wire monitor and hang guard
    // ********
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (!bus.chip_sel_n)
        begin
            seen_addr <= bus.host_address_in;
            seen_sel <= bus.mem_reg_sel;
        end
        if (!bus.low_write_strobe_n)
            seen_wdata <= bus.host_data_io;
        if (bus.data_oe_dev)
            seen_rdata <= bus.host_data_io;
        if (cycles == LIMIT)
        begin
            bad_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic launch(input logic [25:0] a, input logic wr, input logic [15:0] d,
                          input logic [1:0] be);
        reg_write(HREG_ADDR, {6'h00, a});
        if (wr)
            reg_write(HREG_DATA, {16'h0000, d});
        reg_write(HREG_CTRL, {28'h0000000, be, wr, !wr});
    endtask

    task automatic finish(input logic [25:0] a, input logic wr, input logic [15:0] d,
                          input logic [1:0] be);
        logic [31:0] st;
        int k;
        st = '0;
        k = 0;
        // Done rises before recovery ends, so wait for done with busy low
        while ((st & 32'h3) !== 32'h2 && k < 300)
        begin
            reg_read(HREG_STAT, st);
            k++;
        end
        check(st & 32'h3, 32'h2);
        check({14'h0, seen_sel, seen_addr}, {14'h0, a[17:0]});
        if (wr && be == 2'b11)
            check({16'h0, seen_wdata}, {16'h0, d});
        reg_write(HREG_STAT, 32'h2);
        reg_read(HREG_DATA, st);
        last_q = st[15:0];
    endtask

    task automatic access(input logic [25:0] a, input logic wr, input logic [15:0] d,
                          input logic [1:0] be);
        launch(a, wr, d, be);
        finish(a, wr, d, be);
    endtask

    task automatic rd_expect(input logic [25:0] a, input logic [15:0] e, input logic [15:0] m);
        access(a, 1'b0, 16'h0000, 2'b11);
        check({16'h0, last_q & m}, {16'h0, e});
        check({16'h0, seen_rdata & m}, {16'h0, e});
    endtask

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        refresh_req = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        bad_count = 0;
        compares = 0;
        cycles = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        // ********
        // Straps latched at reset release
        // ********
        check({31'h0, cfg_valid}, 32'h1);
        check({31'h0, gen2}, 32'h1);
        check({31'h0, gpio_out}, 32'h0);
        check({31'h0, big_end}, 32'h0);
        check({24'h0, bus.straps}, {24'h0, EXP_STRAPS});
        check({30'h0, bus.bus_start_n, bus.read_write_n}, 32'h3);
        rd_expect(26'h3FC0000, {8'h00, EXP_STRAPS}, 16'h00FF);
        rd_expect(26'h0000004, 16'h0003, 16'h0007);
        rd_expect(26'h0000006, 16'h0000, 16'hFFFF);
        reg_read(4'h2, rd_val);
        check(rd_val, 32'h0);
        $display("test straps done");
        // ********
        // Internal clock divider
        // ********
        rd_expect(26'h0000002, {12'h000, CLKDIV_RST}, 16'h000F);
        access(26'h0000002, 1'b1, 16'h0003, 2'b11);
        rd_expect(26'h0000002, 16'h0003, 16'h000F);
        @(posedge tick);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
            #1;
        end
        while (tick !== 1'b1 && n < 20);
        check(n, 32'h4);
        $display("test divider done");
        // ********
        // Display buffer, aliasing and byte lanes
        // ********
        access(BUF_A, 1'b1, 16'hA5C3, 2'b11);
        rd_expect(26'h3FE0010, 16'hA5C3, 16'hFFFF);
        access(BUF_A, 1'b1, 16'h1234, 2'b01);
        rd_expect(BUF_A, 16'hA534, 16'hFFFF);
        access(BUF_A, 1'b1, 16'h5600, 2'b10);
        rd_expect(BUF_A, 16'h5634, 16'hFFFF);
        access(26'h0034000, 1'b1, 16'hBEEF, 2'b11);
        rd_expect(26'h0034000, 16'h0000, 16'hFFFF);
        $display("test buffer done");
        // ********
        // Access stalled behind display refresh
        // ********
        @(posedge clk);
        refresh_req <= 1'b1;
        launch(BUF_A, 1'b0, 16'h0000, 2'b11);
        repeat (20) @(posedge clk);
        reg_read(HREG_STAT, rd_val);
        check(rd_val & 32'h3, 32'h1);
        check({31'h0, bus.wait_line}, 32'h0);
        @(posedge clk);
        refresh_req <= 1'b0;
        finish(BUF_A, 1'b0, 16'h0000, 2'b11);
        check({16'h0, last_q}, 32'h5634);
        $display("test refresh done");
        print_verdict();
    end
endmodule
`default_nettype wire
